// [rtl/thermal_overload_control.sv]
// Mode, force, group selection, curve choice, event and counter logic.
// Assumes RMS current samples arrive with a one-cycle valid every 5 ms.
`timescale 1ns/1ps
module thermal_overload_control
    import tol_pkg::*;
(
    input  wire logic                     ref_clk,
    input  wire logic                     nrst,
    input  wire logic [CUR_W-1:0]         phase_a_rms_current,
    input  wire logic [CUR_W-1:0]         phase_b_rms_current,
    input  wire logic [CUR_W-1:0]         phase_c_rms_current,
    input  wire logic [CUR_W-1:0]         positive_sequence_current,
    input  wire logic [CUR_W-1:0]         negative_sequence_current,
    input  wire logic [TEMP_W-1:0]        ambient_temp_c,
    input  wire logic                     sample_valid,
    input  wire logic                     block_in,
    input  wire logic [GRP_W-1:0]         group_sel,
    input  wire logic [2:0]               ln_mode,
    input  wire logic                     func_enable,
    input  wire logic [2:0]               status_force,
    input  wire logic                     temp_unit_f,
    input  wire logic                     dual_tc_en,
    input  wire logic [15:0]              motor_in_pu,
    input  wire logic [15:0]              motor_in_amp,
    input  wire logic                     cfg_wr,
    input  wire logic [GRP_W-1:0]         cfg_group,
    input  wire group_t                   cfg_data,
    input  wire logic                     counter_clear,
    input  wire logic [TEMP_W-1:0]        replica_temp_c,
    output logic                          trip,
    output logic                          alarm1,
    output logic                          alarm2,
    output logic                          inhibit,
    output logic                          blocked,
    output logic [1:0]                    curve_sel,
    output logic                          motor_stopped,
    output logic [TEMP_W-1:0]             replica_temp_disp,
    output logic [TEMP_W-1:0]             ambient_temp_disp,
    output logic [CUR_W-1:0]              max_phase_current,
    output logic [15:0]                   motor_in_pu_q_out,
    output logic [15:0]                   motor_in_amp_q_out,
    output logic                          event_valid,
    output logic [2:0]                    event_src,
    output logic                          event_on,
    output logic [STAMP_W-1:0]            event_stamp,
    output logic [CNT_W-1:0]              trip_count,
    output logic [CNT_W-1:0]              alarm1_count,
    output logic [CNT_W-1:0]              alarm2_count,
    output logic [CNT_W-1:0]              inhibit_count,
    output logic [CNT_W-1:0]              blocked_count
);
    group_if gp ();

    group_mem u_mem (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .gp      (gp)
    );

    // Synchronisers for the asynchronous control levels
    logic         blk_s1_q, blk_s2_q;
    logic [2:0]   grp_s1_q, grp_s2_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            blk_s1_q <= 1'b0;
            blk_s2_q <= 1'b0;
            grp_s1_q <= 3'h0;
            grp_s2_q <= 3'h0;
        end else begin
            blk_s1_q <= block_in;
            blk_s2_q <= blk_s1_q;
            grp_s1_q <= group_sel;
            grp_s2_q <= grp_s1_q;
        end
    end

    always_comb begin
        gp.wr_en   = cfg_wr;
        gp.wr_idx  = cfg_group;
        gp.wr_data = cfg_data;
        gp.rd_idx  = grp_s2_q;
    end

    // Millisecond timestamp
    logic [15:0]        ms_div_q, ms_div_d;
    logic [STAMP_W-1:0] stamp_q, stamp_d;
    always_comb begin
        ms_div_d = ms_div_q + 16'h0001;
        stamp_d  = stamp_q;
        if (ms_div_q == 16'(MS_CYCLES - 1)) begin
            ms_div_d = 16'h0000;
            stamp_d  = stamp_q + 32'h0000_0001;
        end
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ms_div_q <= 16'h0000;
            stamp_q  <= 32'h0000_0000;
        end else begin
            ms_div_q <= ms_div_d;
            stamp_q  <= stamp_d;
        end
    end

    // Sample capture; inputs are already true RMS over 32 harmonics
    logic [CUR_W-1:0]  imax_q, imax_d;
    logic [TEMP_W-1:0] amb_q, amb_d;
    logic [CUR_W-1:0]  ab_max;
    always_comb begin
        ab_max = (phase_a_rms_current > phase_b_rms_current) ?
                 phase_a_rms_current : phase_b_rms_current;
        imax_d = imax_q;
        amb_d  = amb_q;
        if (sample_valid) begin
            imax_d = (ab_max > phase_c_rms_current) ? ab_max : phase_c_rms_current;
            amb_d  = ambient_temp_c;
        end
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            imax_q <= '0;
            amb_q  <= '0;
        end else begin
            imax_q <= imax_d;
            amb_q  <= amb_d;
        end
    end

    // Curve choice and status decision
    logic        stop_d, act_d, off_d, blk_d;
    logic [1:0]  curve_d;
    logic [4:0]  outs_d;
    logic [15:0] rep_disp_d, amb_disp_d;
    always_comb begin
        stop_d = (imax_q < gp.rd_data.no_load);
        curve_d = CURVE_NORMAL;
        if (stop_d) begin
            curve_d = CURVE_STOPPED;
        end else if ((dual_tc_en || gp.rd_data.dyn_en) &&
                     imax_q > gp.rd_data.max_ovl) begin
            curve_d = CURVE_STALL;
        end
        off_d = !func_enable || (ln_mode == MODE_OFF);
        blk_d = blk_s2_q || (ln_mode == MODE_BLOCKED) ||
                (ln_mode == MODE_TEST_BLK);
        act_d = !off_d && !blk_d;
        outs_d = 5'b00000;
        if (act_d) begin
            outs_d[IDX_TRIP]    = imax_q >= gp.rd_data.trip_lvl && gp.rd_data.trip_lvl != 0;
            outs_d[IDX_ALARM1]  = imax_q >= gp.rd_data.alarm1_lvl && gp.rd_data.alarm1_lvl != 0;
            outs_d[IDX_ALARM2]  = imax_q >= gp.rd_data.alarm2_lvl && gp.rd_data.alarm2_lvl != 0;
            // Restart inhibited while current sits at or above the nominal start level
            outs_d[IDX_INHIBIT] = imax_q >= gp.rd_data.nom_start;
        end else begin
            outs_d[IDX_BLOCKED] = 1'b1;
        end
        case (status_force)
            FORCE_NORMAL:  ;
            FORCE_BLOCKED: outs_d = 5'b10000;
            FORCE_ALARM1:  outs_d = 5'b00010;
            FORCE_ALARM2:  outs_d = 5'b00100;
            FORCE_INHIBIT: outs_d = 5'b01000;
            FORCE_TRIP:    outs_d = 5'b00001;
            default:       ;
        endcase
        // F = C * 9/5 + 32, integer degrees
        rep_disp_d = replica_temp_c;
        amb_disp_d = amb_q;
        if (temp_unit_f) begin
            rep_disp_d = 16'((32'(replica_temp_c) * 9) / 5 + 32);
            amb_disp_d = 16'((32'(amb_q) * 9) / 5 + 32);
        end
    end

    logic [4:0]  outs_q;
    logic [1:0]  curve_q;
    logic        stop_q;
    logic [15:0] rep_disp_q, amb_disp_q, in_pu_q, in_amp_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            outs_q     <= 5'b00000;
            curve_q    <= 2'b00;
            stop_q     <= 1'b1;
            rep_disp_q <= 16'h0000;
            amb_disp_q <= 16'h0000;
            in_pu_q    <= MOTOR_IN_RST;
            in_amp_q   <= MOTOR_IN_A_RST;
        end else begin
            outs_q     <= outs_d;
            curve_q    <= curve_d;
            stop_q     <= stop_d;
            rep_disp_q <= rep_disp_d;
            amb_disp_q <= amb_disp_d;
            in_pu_q    <= motor_in_pu;
            in_amp_q   <= motor_in_amp;
        end
    end

    // Edge events: one per cycle, lowest index first; others wait
    logic [4:0]         prev_q, prev_d;
    logic               ev_v_q, ev_v_d, ev_on_q, ev_on_d;
    logic [2:0]         ev_src_q, ev_src_d;
    logic [STAMP_W-1:0] ev_st_q, ev_st_d;
    logic [4:0]         diff;
    always_comb begin
        diff     = outs_q ^ prev_q;
        prev_d   = prev_q;
        ev_v_d   = 1'b0;
        ev_on_d  = ev_on_q;
        ev_src_d = ev_src_q;
        ev_st_d  = ev_st_q;
        for (int i = NUM_OUT - 1; i >= 0; i--) begin
            if (diff[i]) begin
                ev_src_d = 3'(i);
            end
        end
        if (diff != 5'b00000) begin
            ev_v_d            = 1'b1;
            ev_on_d           = outs_q[ev_src_d];
            ev_st_d           = stamp_q;
            prev_d[ev_src_d]  = outs_q[ev_src_d];
        end
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prev_q   <= 5'b00000;
            ev_v_q   <= 1'b0;
            ev_on_q  <= 1'b0;
            ev_src_q <= 3'h0;
            ev_st_q  <= 32'h0000_0000;
        end else begin
            prev_q   <= prev_d;
            ev_v_q   <= ev_v_d;
            ev_on_q  <= ev_on_d;
            ev_src_q <= ev_src_d;
            ev_st_q  <= ev_st_d;
        end
    end

    // Rising-event counters; a same-cycle count adds one on top of the clear
    logic [CNT_W-1:0] cnt_q [NUM_OUT];
    logic [CNT_W-1:0] cnt_d [NUM_OUT];
    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g++) begin : g_cnt
            always_comb begin
                cnt_d[g] = counter_clear ? '0 : cnt_q[g];
                if (ev_v_d && ev_on_d && ev_src_d == 3'(g)) begin
                    cnt_d[g] = (counter_clear ? '0 : cnt_q[g]) + 16'h0001;
                end
            end
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    cnt_q[g] <= '0;
                end else begin
                    cnt_q[g] <= cnt_d[g];
                end
            end
        end
    endgenerate

    assign trip               = outs_q[IDX_TRIP];
    assign alarm1             = outs_q[IDX_ALARM1];
    assign alarm2             = outs_q[IDX_ALARM2];
    assign inhibit            = outs_q[IDX_INHIBIT];
    assign blocked            = outs_q[IDX_BLOCKED];
    assign curve_sel          = curve_q;
    assign motor_stopped      = stop_q;
    assign replica_temp_disp  = rep_disp_q;
    assign ambient_temp_disp  = amb_disp_q;
    assign max_phase_current  = imax_q;
    assign motor_in_pu_q_out  = in_pu_q;
    assign motor_in_amp_q_out = in_amp_q;
    assign event_valid        = ev_v_q;
    assign event_src          = ev_src_q;
    assign event_on           = ev_on_q;
    assign event_stamp        = ev_st_q;
    assign trip_count         = cnt_q[IDX_TRIP];
    assign alarm1_count       = cnt_q[IDX_ALARM1];
    assign alarm2_count       = cnt_q[IDX_ALARM2];
    assign inhibit_count      = cnt_q[IDX_INHIBIT];
    assign blocked_count      = cnt_q[IDX_BLOCKED];
endmodule // thermal_overload_control

// [inc/tol_pkg.sv]
// Constants and types shared by the thermal overload control logic.
// Assumes a 10 MHz ref_clk and fixed-point settings in tenths (0.1 steps).
// Functional notes
// - Eight setting groups, one common selector
// - Block and group changes apply while running
// - Time-stamped event on every output edge
// - Resettable counters: trip, alarms, inhibit, blocked
// - Inputs are full-harmonic true RMS currents
// - Fresh current and temperature samples every 5 ms
// - Node mode 1..5, default On
// - Activation 0 disabled, 1 active, default disabled
// - Status force 0..5, default normal
// - Temperature unit 0 Celsius, 1 Fahrenheit
// - Automatic trip curve choice with dual/dynamic constants
// - Nominal start current, tenths, default 6.0
// - Motor nominal current per unit, tenths
// - Motor nominal current amperes, tenths
// - Above max overload current use stall constant
// - Below no-load current motor is stopped
package tol_pkg;
    localparam int          CLK_HZ          = 10_000_000;
    localparam int          SAMPLE_MS       = 5;
    localparam int          STAMP_MS        = 1;
    localparam int          MS_CYCLES       = CLK_HZ / 1000 * STAMP_MS;
    localparam int          SAMPLE_CYCLES   = CLK_HZ / 1000 * SAMPLE_MS;
    localparam int          CUR_W           = 16;
    localparam int          TEMP_W          = 16;
    localparam int          CNT_W           = 16;
    localparam int          STAMP_W         = 32;
    localparam int          NUM_GROUPS      = 8;
    localparam int          GRP_W           = 3;
    localparam int          NUM_OUT         = 5;
    localparam logic [15:0] NOM_START_RST   = 16'h003C; // 6.0 in tenths
    localparam logic [15:0] MAX_OVL_RST     = 16'h0014; // 2.0 in tenths
    localparam logic [15:0] NO_LOAD_RST     = 16'h0002; // 0.2 in tenths
    localparam logic [15:0] MOTOR_IN_RST    = 16'h000A; // 1.0 in tenths
    localparam logic [15:0] MOTOR_IN_A_RST  = 16'h0000;
    localparam int          IDX_TRIP        = 0;
    localparam int          IDX_ALARM1      = 1;
    localparam int          IDX_ALARM2      = 2;
    localparam int          IDX_INHIBIT     = 3;
    localparam int          IDX_BLOCKED     = 4;

    typedef enum logic [2:0] {
        MODE_ON       = 3'b001,
        MODE_BLOCKED  = 3'b010,
        MODE_TEST     = 3'b011,
        MODE_TEST_BLK = 3'b100,
        MODE_OFF      = 3'b101
    } ln_mode_t;

    typedef enum logic [2:0] {
        FORCE_NORMAL  = 3'b000,
        FORCE_BLOCKED = 3'b001,
        FORCE_ALARM1  = 3'b010,
        FORCE_ALARM2  = 3'b011,
        FORCE_INHIBIT = 3'b100,
        FORCE_TRIP    = 3'b101
    } force_t;

    typedef enum logic [1:0] {
        CURVE_NORMAL  = 2'b00,
        CURVE_STALL   = 2'b01,
        CURVE_STOPPED = 2'b10
    } curve_t;

    typedef struct packed {
        logic [15:0] nom_start;
        logic [15:0] max_ovl;
        logic [15:0] no_load;
        logic [15:0] alarm1_lvl;
        logic [15:0] alarm2_lvl;
        logic [15:0] trip_lvl;
        logic        dyn_en;
    } group_t;
    localparam int GROUP_W = $bits(group_t);
endpackage

// [inc/group_if.sv]
// Setting-group storage port between the control top and its memory.
// Assumes a single clock shared by both sides.
`timescale 1ns/1ps
interface group_if;
    import tol_pkg::*;
    logic                 wr_en;
    logic [GRP_W-1:0]     wr_idx;
    group_t               wr_data;
    logic [GRP_W-1:0]     rd_idx;
    group_t               rd_data;
    modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
    modport mem  (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface

// [rtl/group_mem.sv]
// Eight-entry setting-group memory with registered read data.
// Assumes writes come from the control top on the same clock.
`timescale 1ns/1ps
module group_mem
    import tol_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic nrst,
    group_if.mem      gp
);
    group_t mem_q [NUM_GROUPS];
    group_t rd_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NUM_GROUPS; i++) begin
                mem_q[i] <= '{NOM_START_RST, MAX_OVL_RST, NO_LOAD_RST,
                              16'h0000, 16'h0000, 16'h0000, 1'b0};
            end
            rd_q <= '0;
        end else begin
            if (gp.wr_en) begin
                mem_q[gp.wr_idx] <= gp.wr_data;
            end
            rd_q <= mem_q[gp.rd_idx];
        end
    end

    assign gp.rd_data = rd_q;
endmodule // group_mem

// [verification/tol_checker_properties.sv]
// Port assertions for thermal_overload_control, bound from the bench top.
// Assumes one clock domain with the async active-low reset.
`timescale 1ns/1ps
module tol_checker (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        block_in,
    input wire logic        func_enable,
    input wire logic [2:0]  status_force,
    input wire logic        temp_unit_f,
    input wire logic        counter_clear,
    input wire logic [15:0] replica_temp_c,
    input wire logic        trip,
    input wire logic        alarm1,
    input wire logic        alarm2,
    input wire logic        inhibit,
    input wire logic        blocked,
    input wire logic [15:0] replica_temp_disp,
    input wire logic        event_valid,
    input wire logic [2:0]  event_src,
    input wire logic        event_on,
    input wire logic [15:0] trip_count,
    input wire logic [15:0] blocked_count
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    a_celsius_disp: assert property (($stable(replica_temp_c) && !temp_unit_f)[*3] |->
        replica_temp_disp == replica_temp_c) else $error("celsius display wrong");
    a_off_quiet: assert property ((!func_enable && status_force == 3'h0)[*3] |->
        blocked && !trip && !alarm1 && !alarm2 && !inhibit) else $error("active while off");
    a_block_input: assert property ((block_in && status_force == 3'h0)[*5] |->
        blocked && !trip) else $error("block input ignored");
    a_force_trip: assert property ((status_force == 3'h5)[*3] |-> trip)
        else $error("trip force ignored");
    a_trip_event: assert property ($rose(trip) |->
        ##[1:5] (event_valid && event_src == 3'h0 && event_on)) else $error("no trip event");
    a_unblock_event: assert property ($fell(blocked) |->
        ##[1:5] (event_valid && event_src == 3'h4 && !event_on)) else $error("no unblock event");
    a_trip_count: assert property (event_valid && event_src == 3'h0 && event_on
        && !$past(counter_clear) |-> trip_count == $past(trip_count) + 16'h0001)
        else $error("trip count not advanced");
    a_count_clear: assert property ($past(counter_clear) && !event_valid |->
        trip_count == 16'h0000 && blocked_count == 16'h0000) else $error("counts not cleared");
endmodule // tol_checker

// [verification/front_end_model.sv]
// Front end model: RMS samples with a one-cycle strobe every PERIOD cycles.
// Assumes the bench sets the load level; the ambient reading is fixed.
`timescale 1ns/1ps
module front_end_model #(
    parameter int PERIOD = 20
) (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic [15:0] level,
    output logic     [15:0] ia,
    output logic     [15:0] ib,
    output logic     [15:0] ic,
    output logic     [15:0] ipos,
    output logic     [15:0] ineg,
    output logic     [15:0] amb,
    output logic            valid
);
    int cnt_q;
    int rot_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 0;
            rot_q <= 0;
            valid <= 1'b0;
        end else begin
            valid <= (cnt_q == PERIOD - 1);
            cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
            rot_q <= valid ? (rot_q + 1) % 3 : rot_q;
        end
    end
    // Peak moves between phases; lines carry the inverse outside strobes
    always_comb begin
        ia = valid ? level >> rot_q : ~level;
        ib = valid ? level >> ((rot_q + 1) % 3) : ~level;
        ic = valid ? level >> ((rot_q + 2) % 3) : ~level;
        ipos = valid ? level : ~level;
        ineg = valid ? level >> 3 : ~level;
        amb = valid ? 16'h0014 : 16'hFFEB;
    end
endmodule // front_end_model

// [verification/thermal_overload_control_tb_top.sv]
// Self-checking bench for thermal_overload_control with a front end model.
// Assumes tol_checker and front_end_model are compiled beforehand.
`timescale 1ns/1ps
module thermal_overload_control_tb_top;
    import tol_pkg::*;
    localparam int PER = 20;
    logic        ref_clk, nrst, sample_valid, block_in, func_enable, temp_unit_f;
    logic        dual_tc_en, cfg_wr, counter_clear, trip, alarm1, alarm2, inhibit;
    logic        blocked, motor_stopped, event_valid, event_on;
    logic [1:0]  curve_sel;
    logic [2:0]  group_sel, ln_mode, status_force, cfg_group, event_src;
    logic [15:0] phase_a_rms_current, phase_b_rms_current, phase_c_rms_current;
    logic [15:0] positive_sequence_current, negative_sequence_current, ambient_temp_c;
    logic [15:0] motor_in_pu, motor_in_amp, replica_temp_c, replica_temp_disp, level;
    logic [15:0] ambient_temp_disp, max_phase_current, motor_in_pu_q_out, motor_in_amp_q_out;
    logic [15:0] trip_count, alarm1_count, alarm2_count, inhibit_count, blocked_count;
    logic [31:0] event_stamp, s0;
    logic [35:0] ev_q[$];
    group_t      cfg_data;
    int          n_fail, comparisons;
    int          map[6] = '{0, 4, 1, 2, 3, 0};

    front_end_model #(.PERIOD(PER)) i_fe (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .level(level),
        .ia(phase_a_rms_current),
        .ib(phase_b_rms_current),
        .ic(phase_c_rms_current),
        .ipos(positive_sequence_current),
        .ineg(negative_sequence_current),
        .amb(ambient_temp_c),
        .valid(sample_valid)
    );
    thermal_overload_control i_dut (.*);

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // Sampled mid-cycle so the event word has settled
    always @(negedge ref_clk) begin
        if (event_valid === 1'b1)
            ev_q.push_back({event_src, event_on, event_stamp});
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #10;
    endtask

    task automatic chk(input string nm, input logic [79:0] got, input logic [79:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    function automatic logic [4:0] outs();
        return {blocked, inhibit, alarm2, alarm1, trip};
    endfunction

    // Strobe is lowered and an edge passes, so back-to-back calls never collide
    task automatic cfg(input logic [2:0] g, input group_t d);
        cfg_wr = 1'b1;
        cfg_group = g;
        cfg_data = d;
        tick(1);
        cfg_wr = 1'b0;
        tick(1);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge ref_clk);
        n_fail++;
        end_of_test();
    end

    initial begin
        nrst = 1'b0;
        level = 16'h000A;
        {block_in, func_enable, temp_unit_f, dual_tc_en, cfg_wr, counter_clear} = 6'h00;
        {group_sel, status_force, cfg_group} = 9'h000;
        ln_mode = 3'h1;
        motor_in_pu = 16'h0032;
        motor_in_amp = 16'h04D2;
        replica_temp_c = 16'h0064;
        cfg_data = '0;
        tick(6);
        chk("reset", {motor_stopped, motor_in_pu_q_out}, 17'h1_000A);
        nrst = 1'b1;
        tick(10);
        chk("off", outs(), 5'h10);
        chk("blk ev", ev_q[0][35:32], 4'h9);
        chk("in", {motor_in_pu_q_out, motor_in_amp_q_out}, 32'h0032_04D2);
        s0 = ev_q[0][31:0];
        cfg(3'h0, '{16'h003C, 16'h0014, 16'h0002, 16'h0032, 16'h0050, 16'h0064, 1'b0});
        cfg(3'h7, '{16'h0096, 16'h0014, 16'h0002, 16'h0000, 16'h0000, 16'h00C8, 1'b0});
        tick(25000);
        ev_q.delete();
        func_enable = 1'b1;
        tick(8);
        chk("on", outs(), 5'h00);
        chk("unblk ev", ev_q[0][35:32], 4'h8);
        chk("stamp", (ev_q[0][31:0] - s0) inside {32'h2, 32'h3}, 1'b1);
        $display("test reset done");
        ev_q.delete();
        level = 16'h0078;
        tick(2 * PER + 8);
        chk("peak", max_phase_current, 16'h0078);
        chk("load", outs(), 5'h0F);
        for (int i = 0; i < 4; i++) begin
            chk("order", ev_q[i][35:32], {i[2:0], 1'b1});
        end
        chk("counts", {trip_count, alarm1_count, alarm2_count, inhibit_count, blocked_count},
            80'h0001_0001_0001_0001_0001);
        counter_clear = 1'b1;
        tick(1);
        counter_clear = 1'b0;
        tick(2);
        chk("clear", {trip_count, alarm1_count, alarm2_count, inhibit_count, blocked_count},
            80'h0);
        group_sel = 3'h7;
        tick(8);
        chk("group", outs(), 5'h00);
        group_sel = 3'h0;
        for (int m = 1; m <= 5; m++) begin
            ln_mode = m[2:0];
            tick(8);
            chk("mode", outs(), (m == 2 || m >= 4) ? 5'h10 : 5'h0F);
        end
        // Block settles before leaving Off, so blocked never drops for a pulse
        block_in = 1'b1;
        tick(4);
        ln_mode = 3'h1;
        tick(8);
        chk("block", outs(), 5'h10);
        block_in = 1'b0;
        level = 16'h000A;
        tick(2 * PER + 8);
        for (int f = 0; f < 6; f++) begin
            status_force = f[2:0];
            tick(6);
            chk("force", outs(), (f == 0) ? 5'h00 : 5'h01 << map[f]);
        end
        status_force = 3'h0;
        $display("test modes done");
        dual_tc_en = 1'b1;
        level = 16'h001E;
        tick(2 * PER + 8);
        chk("stall", curve_sel, CURVE_STALL);
        dual_tc_en = 1'b0;
        tick(4);
        chk("single", curve_sel, CURVE_NORMAL);
        level = 16'h0001;
        tick(2 * PER + 8);
        chk("stop", {curve_sel, motor_stopped}, {CURVE_STOPPED, 1'b1});
        temp_unit_f = 1'b1;
        tick(4);
        chk("deg f", {replica_temp_disp, ambient_temp_disp}, 32'h00D4_0044);
        temp_unit_f = 1'b0;
        tick(4);
        chk("deg c", {replica_temp_disp, ambient_temp_disp}, 32'h0064_0014);
        $display("test curves done");
        end_of_test();
    end
endmodule // thermal_overload_control_tb_top

bind thermal_overload_control tol_checker i_chk (.*);
